// ===== design/nats_map.vh
// Register map, field positions and timing figures of the target sequencer
`ifndef NATS_MAP_VH
`define NATS_MAP_VH
`define NATS_REG_MODE 8'h00
`define NATS_REG_AUX 8'h04
`define NATS_REG_OPCTL 8'h08
`define NATS_REG_RATE_DEF 8'h0c
`define NATS_REG_RATE_DET 8'h10
`define NATS_REG_STATUS 8'h14
`define NATS_REG_CMD 8'h18
`define NATS_REG_MRT 8'h1c
`define NATS_REG_NRT 8'h20
`define NATS_REG_GPT 8'h24
`define NATS_REG_AM_CTL 8'h28
`define NATS_REG_MOD_LVL 8'h2c
`define NATS_REG_DEPTH_DISP 8'h30
// Mode register fields
`define NATS_MODE_TARG 0
`define NATS_MODE_RATE_DET 1
`define NATS_MODE_AUTO_CA 2
`define NATS_MODE_GPT_MASK 3
`define NATS_MODE_RST 4'h2
// Auxiliary register fields
`define NATS_AUX_FD_EN 0
`define NATS_AUX_SLOT_LO 1
`define NATS_AUX_SLOT_HI 2
`define NATS_AUX_MOD_SEL 3
`define NATS_AUX_START_BYTE 4
`define NATS_AUX_AM_CH 5
`define NATS_AUX_PM_CH 6
`define NATS_AUX_RST 7'h60
// Operation control: oscillator, regulator, receiver
`define NATS_OP_RST 3'h0
// Direct command codes (cmd[3:0]) and preset protocol (cmd[6:4])
`define NATS_CMD_START_MRT 4'h1
`define NATS_CMD_GO_NORMAL 4'h2
`define NATS_CMD_PRESET 4'h3
`define NATS_CMD_CAL_DEPTH 4'h4
`define NATS_PROTO_A106 3'h0
`define NATS_PROTO_B 3'h1
`define NATS_PROTO_F212 3'h2
`define NATS_PROTO_P2P106 3'h3
`define NATS_PROTO_P2P212 3'h4
`define NATS_PROTO_P2P424 3'h5
// AM control: level source select in bit 7, target depth in bits 6:1
`define NATS_AM_SEL 7
`define NATS_TMR_RST 16'h0000
// Timing
`define NATS_CLK_NS 10
`define NATS_TICK_NS 1000
`define NATS_TICK_CYC (`NATS_TICK_NS / `NATS_CLK_NS)
`define NATS_RESP_WAIT_NS 56600
`define NATS_SLOT_NS 37800
`define NATS_GUARD_NS 75500
`define NATS_RESP_WAIT_CYC (`NATS_RESP_WAIT_NS / `NATS_CLK_NS)
`define NATS_SLOT_CYC (`NATS_SLOT_NS / `NATS_CLK_NS)
`define NATS_GUARD_CYC (`NATS_GUARD_NS / `NATS_CLK_NS)
`endif

// ===== design/nats_target_seq.v
// NFC active target sequencer with Avalon-MM register slave
//
// The address map and the Avalon-MM slave port were decided locally.
`include "nats_map.vh"
// Behaviour
// - Writing target-select 1 enters target mode and sets field detector enable.
// - Target mode with operation control all zero is low-power, detector only.
// - Sub-mode bit picks rate detection into display register, or normal rate.
// - Initiator field seen in low-power rate detection raises field-on event.
// - After mask timer command expires, receiver output is watched for start.
// - Message start raises event, enables rate recognizer in rate detection sub-mode; rate found loads display.
// - Auto response collision avoidance only after a rate is detected, or in normal sub-mode.
// - Received frame end raises the usual end-of-receive event.
// - Go-normal command copies detected rate and selects normal sub-mode.
// - Peer field loss raises field-off; auto response starts with slot count.
// - No collision: field on, collision-done event after response guard time.
// - After reply, field off after general timer; its event maskable.
// - Field off starts no-response timer; no initiator field gives timeout event.
// - Field-on in loop auto-starts mask timer, then reception proceeds.
// - Modulation select picks OOK or AM; preset picks AM for B, F212, P2P212 and P2P424.
// - AM depth comes from calibration result or the level definition register.
// - P2P preset enables AM channel only and the transport start byte.
module nats_target_seq #(
  parameter RESP_WAIT_CYC = `NATS_RESP_WAIT_CYC,
  parameter SLOT_CYC = `NATS_SLOT_CYC,
  parameter GUARD_CYC = `NATS_GUARD_CYC,
  parameter TICK_CYC = `NATS_TICK_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // RF field detector pin
  input wire ext_field_in,
  // Framing and transmitter status
  input wire rx_start,
  input wire rx_rate_valid,
  input wire [1:0] rx_rate,
  input wire rx_end,
  input wire tx_done,
  input wire [7:0] cal_level,
  // Front end control
  output reg field_on,
  output reg rx_watch,
  output reg rate_recog_en,
  output reg low_power,
  output reg ca_threshold_sel,
  output reg modulation_select,
  output reg [7:0] am_level,
  // Event pulses to host
  output reg evt_field_on,
  output reg evt_field_off,
  output reg evt_rx_start,
  output reg evt_rate_det,
  output reg evt_rx_end,
  output reg evt_ca_done,
  output reg evt_gpt,
  output reg evt_no_resp
);

  localparam [8:0] S_OFF = 9'h001;
  localparam [8:0] S_LP = 9'h002;
  localparam [8:0] S_MASK = 9'h004;
  localparam [8:0] S_LISTEN = 9'h008;
  localparam [8:0] S_CA = 9'h010;
  localparam [8:0] S_GUARD = 9'h020;
  localparam [8:0] S_TX = 9'h040;
  localparam [8:0] S_HOLD = 9'h080;
  localparam [8:0] S_NORESP = 9'h100;

  reg [3:0] mode_q;
  reg [6:0] aux_q;
  reg [2:0] op_q;
  reg [1:0] rate_def_q;
  reg [1:0] rate_det_q;
  reg rate_ok_q;
  reg [15:0] mrt_q;
  reg [15:0] nrt_q;
  reg [15:0] gpt_q;
  reg [7:0] am_ctl_q;
  reg [7:0] mod_lvl_q;
  reg [7:0] depth_disp_q;
  reg [8:0] state_q;
  reg [15:0] tmr_q;
  reg [16:0] cyc_q;
  reg [6:0] tick_q;
  reg fd_s1_q;
  reg fd_s2_q;
  reg fd_prev_q;

  wire acc = (avs_read | avs_write) & avs_waitrequest;
  wire wr_go = avs_write & ~avs_waitrequest;
  wire [3:0] cmd = avs_writedata[3:0];
  wire [2:0] proto = avs_writedata[6:4];
  wire cmd_go = wr_go & (avs_address == `NATS_REG_CMD);
  wire targ = mode_q[`NATS_MODE_TARG];
  wire rate_mode = mode_q[`NATS_MODE_RATE_DET];
  // Detector output only counts while enabled
  wire fd_now = fd_s2_q & aux_q[`NATS_AUX_FD_EN];
  wire fd_rise = fd_now & ~fd_prev_q;
  wire fd_fall = ~fd_now & fd_prev_q;
  wire tick = (tick_q == 7'h00);
  wire tmr_done = tick & (tmr_q == 16'h0000);
  wire [1:0] slots = {aux_q[`NATS_AUX_SLOT_HI], aux_q[`NATS_AUX_SLOT_LO]};
  wire is_p2p = (proto == `NATS_PROTO_P2P106) | (proto == `NATS_PROTO_P2P212) |
    (proto == `NATS_PROTO_P2P424);
  wire use_am = (proto == `NATS_PROTO_B) | (proto == `NATS_PROTO_F212) |
    (proto == `NATS_PROTO_P2P212) | (proto == `NATS_PROTO_P2P424);
  wire [16:0] ca_wait = RESP_WAIT_CYC[16:0] + slots * SLOT_CYC[16:0];

  // Pin synchroniser; only the second stage is read by logic
  always @(posedge core_clk) begin
    if (!rstn) begin
      fd_s1_q <= 1'b0;
      fd_s2_q <= 1'b0;
      fd_prev_q <= 1'b0;
    end else begin
      fd_s1_q <= ext_field_in;
      fd_s2_q <= fd_s1_q;
      fd_prev_q <= fd_now;
    end
  end

  // Timer tick divider
  always @(posedge core_clk) begin
    if (!rstn || tick) begin
      tick_q <= TICK_CYC[6:0] - 7'h01;
    end else begin
      tick_q <= tick_q - 7'h01;
    end
  end

  // Bus handshake: one wait cycle, then the transfer completes
  always @(posedge core_clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~acc;
      if (acc && avs_read) begin
        case (avs_address)
          `NATS_REG_MODE: avs_readdata <= {28'h0, mode_q};
          `NATS_REG_AUX: avs_readdata <= {25'h0, aux_q};
          `NATS_REG_OPCTL: avs_readdata <= {29'h0, op_q};
          `NATS_REG_RATE_DEF: avs_readdata <= {30'h0, rate_def_q};
          `NATS_REG_RATE_DET: avs_readdata <= {30'h0, rate_det_q};
          `NATS_REG_STATUS: avs_readdata <= {20'h0, field_on, fd_now, rate_ok_q, state_q};
          `NATS_REG_MRT: avs_readdata <= {16'h0, mrt_q};
          `NATS_REG_NRT: avs_readdata <= {16'h0, nrt_q};
          `NATS_REG_GPT: avs_readdata <= {16'h0, gpt_q};
          `NATS_REG_AM_CTL: avs_readdata <= {24'h0, am_ctl_q};
          `NATS_REG_MOD_LVL: avs_readdata <= {24'h0, mod_lvl_q};
          `NATS_REG_DEPTH_DISP: avs_readdata <= {24'h0, depth_disp_q};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-written registers and direct commands
  always @(posedge core_clk) begin
    if (!rstn) begin
      mode_q <= `NATS_MODE_RST;
      aux_q <= `NATS_AUX_RST;
      op_q <= `NATS_OP_RST;
      rate_def_q <= 2'h0;
      mrt_q <= `NATS_TMR_RST;
      nrt_q <= `NATS_TMR_RST;
      gpt_q <= `NATS_TMR_RST;
      am_ctl_q <= 8'h00;
      mod_lvl_q <= 8'h00;
      depth_disp_q <= 8'h00;
    end else if (wr_go) begin
      case (avs_address)
        `NATS_REG_MODE: begin
          mode_q <= avs_writedata[3:0];
          if (avs_writedata[`NATS_MODE_TARG]) begin
            aux_q[`NATS_AUX_FD_EN] <= 1'b1;
          end
        end
        `NATS_REG_AUX: aux_q <= avs_writedata[6:0];
        `NATS_REG_OPCTL: op_q <= avs_writedata[2:0];
        `NATS_REG_RATE_DEF: rate_def_q <= avs_writedata[1:0];
        `NATS_REG_MRT: mrt_q <= avs_writedata[15:0];
        `NATS_REG_NRT: nrt_q <= avs_writedata[15:0];
        `NATS_REG_GPT: gpt_q <= avs_writedata[15:0];
        `NATS_REG_AM_CTL: am_ctl_q <= avs_writedata[7:0];
        `NATS_REG_MOD_LVL: mod_lvl_q <= avs_writedata[7:0];
        `NATS_REG_CMD: begin
          case (cmd)
            `NATS_CMD_GO_NORMAL: begin
              rate_def_q <= rate_det_q;
              mode_q[`NATS_MODE_RATE_DET] <= 1'b0;
            end
            `NATS_CMD_PRESET: begin
              aux_q[`NATS_AUX_MOD_SEL] <= use_am;
              aux_q[`NATS_AUX_AM_CH] <= 1'b1;
              aux_q[`NATS_AUX_PM_CH] <= ~is_p2p;
              aux_q[`NATS_AUX_START_BYTE] <= is_p2p;
            end
            `NATS_CMD_CAL_DEPTH: depth_disp_q <= cal_level;
            default: depth_disp_q <= depth_disp_q;
          endcase
        end
        default: mode_q <= mode_q;
      endcase
    end
  end

  // Modulation drive follows the selected source
  always @(posedge core_clk) begin
    if (!rstn) begin
      modulation_select <= 1'b0;
      am_level <= 8'h00;
    end else begin
      modulation_select <= aux_q[`NATS_AUX_MOD_SEL];
      am_level <= am_ctl_q[`NATS_AM_SEL] ? mod_lvl_q : depth_disp_q;
    end
  end

  // Target sequencer
  always @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= S_OFF;
      tmr_q <= `NATS_TMR_RST;
      cyc_q <= 17'h0;
      rate_det_q <= 2'h0;
      rate_ok_q <= 1'b0;
      field_on <= 1'b0;
      rx_watch <= 1'b0;
      rate_recog_en <= 1'b0;
      low_power <= 1'b0;
      ca_threshold_sel <= 1'b0;
      evt_field_on <= 1'b0;
      evt_field_off <= 1'b0;
      evt_rx_start <= 1'b0;
      evt_rate_det <= 1'b0;
      evt_rx_end <= 1'b0;
      evt_ca_done <= 1'b0;
      evt_gpt <= 1'b0;
      evt_no_resp <= 1'b0;
    end else begin
      evt_field_on <= 1'b0;
      evt_field_off <= 1'b0;
      evt_rx_start <= 1'b0;
      evt_rate_det <= 1'b0;
      evt_rx_end <= 1'b0;
      evt_ca_done <= 1'b0;
      evt_gpt <= 1'b0;
      evt_no_resp <= 1'b0;
      low_power <= state_q[1];
      ca_threshold_sel <= state_q[4];
      if (tick && tmr_q != 16'h0000) begin
        tmr_q <= tmr_q - 16'h0001;
      end
      if (cyc_q != 17'h0) begin
        cyc_q <= cyc_q - 17'h1;
      end
      if (!targ) begin
        state_q <= S_OFF;
        field_on <= 1'b0;
        rx_watch <= 1'b0;
        rate_recog_en <= 1'b0;
        rate_ok_q <= 1'b0;
      end else if (op_q == 3'h0 && !state_q[1]) begin
        // Operation control cleared: drop back to the idle wait
        state_q <= S_LP;
        field_on <= 1'b0;
        rx_watch <= 1'b0;
        rate_recog_en <= 1'b0;
        rate_ok_q <= ~rate_mode;
      end else begin
        case (state_q)
          S_OFF: state_q <= S_LP;
          S_LP: begin
            if (fd_rise) begin
              evt_field_on <= 1'b1;
            end
            if (fd_fall) begin
              evt_field_off <= 1'b1;
            end
            if (cmd_go && cmd == `NATS_CMD_START_MRT && op_q != 3'h0) begin
              tmr_q <= mrt_q;
              state_q <= S_MASK;
            end
          end
          S_MASK: begin
            if (tmr_done) begin
              rx_watch <= 1'b1;
              state_q <= S_LISTEN;
            end
          end
          S_LISTEN: begin
            if (rx_start) begin
              evt_rx_start <= 1'b1;
              rate_recog_en <= rate_mode;
            end
            if (rx_rate_valid && rate_recog_en) begin
              rate_det_q <= rx_rate;
              rate_ok_q <= 1'b1;
              evt_rate_det <= 1'b1;
              rate_recog_en <= 1'b0;
            end
            if (rx_end) begin
              evt_rx_end <= 1'b1;
            end
            if (fd_fall) begin
              evt_field_off <= 1'b1;
              if (mode_q[`NATS_MODE_AUTO_CA] && rate_ok_q) begin
                rx_watch <= 1'b0;
                cyc_q <= ca_wait;
                state_q <= S_CA;
              end
            end
          end
          S_CA: begin
            if (fd_now) begin
              // Collision: the peer owns the field, keep listening
              rx_watch <= 1'b1;
              state_q <= S_LISTEN;
            end else if (cyc_q == 17'h0) begin
              field_on <= 1'b1;
              cyc_q <= GUARD_CYC[16:0];
              state_q <= S_GUARD;
            end
          end
          S_GUARD: begin
            if (cyc_q == 17'h0) begin
              evt_ca_done <= 1'b1;
              state_q <= S_TX;
            end
          end
          S_TX: begin
            if (tx_done) begin
              tmr_q <= gpt_q;
              state_q <= S_HOLD;
            end
          end
          S_HOLD: begin
            if (tmr_done) begin
              field_on <= 1'b0;
              evt_gpt <= ~mode_q[`NATS_MODE_GPT_MASK];
              tmr_q <= nrt_q;
              state_q <= S_NORESP;
            end
          end
          S_NORESP: begin
            if (fd_rise) begin
              evt_field_on <= 1'b1;
              tmr_q <= mrt_q;
              state_q <= S_MASK;
            end else if (tmr_done) begin
              evt_no_resp <= 1'b1;
              state_q <= S_LP;
            end
          end
          default: state_q <= S_OFF;
        endcase
      end
    end
  end
endmodule // nats_target_seq

// ===== sim/nats_initiator_model.sv
// Remote active initiator: its RF field and framed message pulses
module nats_initiator_model (
  // Clock
  input wire logic core_clk,
  // Requests from the bench
  input wire logic field_req,
  input wire logic send_req,
  input wire logic [1:0] send_rate,
  // Toward the target
  output logic ext_field_in,
  output logic rx_start,
  output logic rx_rate_valid,
  output logic rx_end,
  output logic [1:0] rx_rate
);
  timeunit 1ns;
  timeprecision 1ps;
  int step = -1;
  initial begin
    ext_field_in = 1'b0;
    rx_start = 1'b0;
    rx_rate_valid = 1'b0;
    rx_end = 1'b0;
    rx_rate = 2'h0;
  end
  always @(posedge core_clk) begin
    ext_field_in <= field_req;
    if (send_req) step <= 0;
    else if (step >= 0 && step < 8) step <= step + 1;
    else step <= -1;
    rx_start <= send_req;
    rx_rate_valid <= (step == 3);
    rx_end <= (step == 7);
    // Rate bus churns when not valid so stale values are never trusted
    rx_rate <= (step == 3) ? send_rate : ~rx_rate;
  end
endmodule // nats_initiator_model

// ===== sim/nats_seq_asserts.sv
// Port-level concurrent checks for the target sequencer
module nats_seq_asserts #(
  parameter GUARD_CYC = 7550
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Far side
  input wire logic ext_field_in,
  input wire logic rx_start,
  input wire logic rx_rate_valid,
  input wire logic rx_end,
  // Front end and events
  input wire logic field_on,
  input wire logic rx_watch,
  input wire logic low_power,
  input wire logic evt_field_off,
  input wire logic evt_rx_start,
  input wire logic evt_rate_det,
  input wire logic evt_rx_end,
  input wire logic evt_ca_done,
  input wire logic evt_gpt,
  input wire logic evt_no_resp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  logic [15:0] gcnt_q;
  // Cycles with own field up, to time the guard
  always @(posedge core_clk) begin
    if (!rstn || !field_on) gcnt_q <= 16'h0000;
    else gcnt_q <= gcnt_q + 16'h0001;
  end
  sequence s_guard_quiet;
    !evt_ca_done [*8];
  endsequence
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus transfer did not finish after one wait cycle");
  a_bus_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_start_evt: assert property (rx_start && rx_watch |=> evt_rx_start)
    else $error("message start not reported");
  a_start_cause: assert property (evt_rx_start |-> $past(rx_start))
    else $error("start event without message start");
  a_rate_cause: assert property (evt_rate_det |-> $past(rx_rate_valid))
    else $error("rate event without recognised rate");
  a_end_cause: assert property (evt_rx_end |-> $past(rx_end))
    else $error("end event without frame end");
  a_guard_time: assert property (evt_ca_done |-> field_on && gcnt_q >= GUARD_CYC - 3 && gcnt_q <= GUARD_CYC + 3)
    else $error("collision done outside guard time");
  a_guard_quiet: assert property ($rose(field_on) |-> s_guard_quiet)
    else $error("collision done too soon after field on");
  a_lp_quiet: assert property (low_power |-> !field_on && !rx_watch)
    else $error("low power state with field or receiver active");
  a_off_cause: assert property (evt_field_off |-> !$past(ext_field_in, 2))
    else $error("field off event while peer field present");
  a_gpt_off: assert property (evt_gpt |-> ##[0:1] !field_on)
    else $error("field still on after hold timer");
  a_noresp_off: assert property (evt_no_resp |-> !field_on && !rx_watch)
    else $error("no response event with field or receiver active");
endmodule // nats_seq_asserts

// ===== sim/nats_target_seq_bench.sv
// Self-checking bench for the target sequencer
`include "nats_map.vh"
module nats_target_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RW = 20;
  localparam int GD = 20;
  // Protocol codes 1, 2, 4 and 5 preset amplitude modulation
  localparam logic [5:0] AM_SET = 6'b110110;
  logic core_clk = 0, rstn = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0] avs_address = 8'h00, cal_level = 8'h00, am_level;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic ext_field_in, rx_start, rx_rate_valid, rx_end, tx_done = 0, field_req = 0, send_req = 0;
  logic [1:0] rx_rate;
  logic field_on, rx_watch, rate_recog_en, low_power, ca_threshold_sel, modulation_select;
  logic evt_field_on, evt_field_off, evt_rx_start, evt_rate_det, evt_rx_end, evt_ca_done;
  logic evt_gpt, evt_no_resp;
  int fail_count = 0, compares = 0, n, cnt;
  wire [11:0] ev = {!field_on, low_power, rx_watch, field_on, evt_no_resp, evt_gpt, evt_ca_done,
    evt_rx_end, evt_rate_det, evt_rx_start, evt_field_off, evt_field_on};
  nats_target_seq #(.RESP_WAIT_CYC(RW), .SLOT_CYC(10), .GUARD_CYC(GD), .TICK_CYC(4)) dut_u (
    .core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .ext_field_in, .rx_start, .rx_rate_valid, .rx_rate, .rx_end, .tx_done,
    .cal_level, .field_on, .rx_watch, .rate_recog_en, .low_power, .ca_threshold_sel,
    .modulation_select, .am_level, .evt_field_on, .evt_field_off, .evt_rx_start, .evt_rate_det,
    .evt_rx_end, .evt_ca_done, .evt_gpt, .evt_no_resp);
  nats_initiator_model ini_u (.core_clk, .field_req, .send_req, .send_rate(2'h2), .ext_field_in,
    .rx_start, .rx_rate_valid, .rx_end, .rx_rate);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  // Entered just after a rising edge; request held until waitrequest sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
    if (n >= 20) chk("bus handshake", 32'h0, 32'h1);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  // Events stand one cycle, so they are looked at on the falling edge
  task wait_ev(input int i, input string nm, input int lim);
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
    end while (ev[i] !== 1'b1 && cnt < lim);
    chk(nm, 32'h1, {31'h0, ev[i]});
    @(posedge core_clk);
  endtask
  task pulse_send();
    send_req <= 1'b1;
    @(posedge core_clk);
    send_req <= 1'b0;
  endtask
  task t_regs();
    rdc("mode reset", `NATS_REG_MODE, 32'h2);
    rdc("aux reset", `NATS_REG_AUX, 32'h60);
    rdc("unmapped read", 8'hfc, 32'h0);
    bus(1'b1, `NATS_REG_MODE, 32'h3);
    rdc("detector enable", `NATS_REG_AUX, 32'h61);
    wait_ev(10, "low power", 10);
  endtask
  task t_modulation();
    for (int p = 0; p < 6; p++) begin
      bus(1'b1, `NATS_REG_CMD, {25'h0, p[2:0], `NATS_CMD_PRESET});
      // Output register lags the auxiliary bit by one edge
      @(posedge core_clk);
      chk("modulation select", {31'h0, AM_SET[p]}, {31'h0, modulation_select});
    end
    rdc("peer preset aux", `NATS_REG_AUX, 32'h39);
    bus(1'b1, `NATS_REG_AM_CTL, 32'h80);
    bus(1'b1, `NATS_REG_MOD_LVL, 32'h5a);
    repeat (2) @(posedge core_clk);
    chk("direct level", 32'h5a, {24'h0, am_level});
    cal_level <= 8'h3c;
    bus(1'b1, `NATS_REG_AM_CTL, 32'h0);
    bus(1'b1, `NATS_REG_CMD, {28'h0, `NATS_CMD_CAL_DEPTH});
    repeat (2) @(posedge core_clk);
    chk("calibrated level", 32'h3c, {24'h0, am_level});
  endtask
  // Rate recognition only runs in the rate detection sub-mode
  task t_frame(input logic det);
    pulse_send();
    wait_ev(2, "rx start event", 10);
    if (det) wait_ev(3, "rate event", 10);
    else chk("recognizer idle", 32'h0, {31'h0, rate_recog_en});
    wait_ev(4, "rx end event", 10);
  endtask
  task t_reply();
    field_req <= 1'b0;
    wait_ev(1, "field off event", 10);
    @(negedge core_clk);
    chk("collision threshold", 32'h1, {31'h0, ca_threshold_sel});
    wait_ev(8, "own field on", 80);
    chk("response wait", 32'h1, {31'h0, cnt >= RW && cnt <= RW + 6});
    wait_ev(5, "collision done", 80);
    chk("guard time", 32'h1, {31'h0, cnt >= GD - 2 && cnt <= GD + 4});
    tx_done <= 1'b1;
    @(posedge core_clk);
    tx_done <= 1'b0;
    wait_ev(6, "hold timer event", 60);
    chk("field off after hold", 32'h0, {31'h0, field_on});
  endtask
  task t_session();
    bus(1'b1, `NATS_REG_MRT, 32'h2);
    bus(1'b1, `NATS_REG_NRT, 32'h28);
    bus(1'b1, `NATS_REG_GPT, 32'h2);
    bus(1'b1, `NATS_REG_AUX, 32'h39);
    bus(1'b1, `NATS_REG_MODE, 32'h7);
    field_req <= 1'b1;
    wait_ev(0, "field on event", 40);
    bus(1'b1, `NATS_REG_OPCTL, 32'h7);
    bus(1'b1, `NATS_REG_CMD, {28'h0, `NATS_CMD_START_MRT});
    wait_ev(9, "receiver watched", 60);
    t_frame(1'b1);
    rdc("detected rate", `NATS_REG_RATE_DET, 32'h2);
    bus(1'b1, `NATS_REG_CMD, {28'h0, `NATS_CMD_GO_NORMAL});
    rdc("copied rate", `NATS_REG_RATE_DEF, 32'h2);
    rdc("normal sub-mode", `NATS_REG_MODE, 32'h5);
    bus(1'b1, `NATS_REG_CMD, {25'h0, `NATS_PROTO_P2P424, `NATS_CMD_PRESET});
    t_reply();
    field_req <= 1'b1;
    wait_ev(0, "loop field on", 20);
    wait_ev(9, "auto mask receive", 60);
    t_frame(1'b0);
    t_reply();
    wait_ev(7, "no response event", 400);
    bus(1'b1, `NATS_REG_OPCTL, 32'h0);
    bus(1'b1, `NATS_REG_MODE, 32'h7);
    rdc("rate detect restored", `NATS_REG_MODE, 32'h7);
    wait_ev(10, "back to low power", 10);
  endtask
  task tally_and_finish();
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_modulation();
    t_session();
    tally_and_finish();
  end
endmodule // nats_target_seq_bench
bind nats_target_seq nats_seq_asserts #(.GUARD_CYC(GUARD_CYC)) chk_u (.core_clk, .rstn, .avs_read,
  .avs_write, .avs_waitrequest, .ext_field_in, .rx_start, .rx_rate_valid, .rx_end, .field_on,
  .rx_watch, .low_power, .evt_field_off, .evt_rx_start, .evt_rate_det, .evt_rx_end,
  .evt_ca_done, .evt_gpt, .evt_no_resp);
